// >>> rtl/lti_pkg.sv
package lti_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] OFS_WAIT_PERIOD = 8'h83;
  localparam logic [7:0] OFS_LOW_LIMIT_LOW_BYTE = 8'h84;
  localparam logic [7:0] OFS_LOW_LIMIT_HIGH_BYTE = 8'h85;
  localparam logic [7:0] OFS_HIGH_LIMIT_LOW_BYTE = 8'h86;
  localparam logic [7:0] OFS_HIGH_LIMIT_HIGH_BYTE = 8'h87;
  localparam logic [7:0] OFS_PERSISTENCE_FILTER = 8'h8c;
  localparam logic [7:0] OFS_CONFIG_WAIT_SCALE = 8'h8d;
  localparam logic [7:0] OFS_CONFIG_GAIN = 8'h90;

  // ==========================================
  // Reset values and field positions
  localparam logic [7:0] RST_WAIT_PERIOD = 8'h00;
  localparam logic [7:0] RST_LIMIT_BYTE = 8'h00;
  localparam logic [7:0] RST_PERSISTENCE_FILTER = 8'h00;
  localparam logic [7:0] RST_CONFIG_WAIT_SCALE = 8'h80;
  localparam logic [7:0] RST_CONFIG_GAIN = 8'h00;
  localparam int PERSISTENCE_FILTER_SEL_MSB = 3;
  localparam int LONG_WAIT_BIT = 2;
  localparam int GAIN_SEL_MSB = 1;

  // ==========================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAIT_STEP_NS = 2800000;
  localparam int WAIT_STEP_CYCLES = WAIT_STEP_NS / CLK_PERIOD_NS;
  localparam logic [3:0] LONG_WAIT_FACTOR = 4'hc;
  localparam int PERSISTENCE_FILTER_CNT_W = 6;
  localparam logic [5:0] PERSISTENCE_FILTER_CNT_MAX = 6'h3f;

  typedef enum logic {
    LTI_WAIT_IDLE,
    LTI_WAIT_RUN
  } lti_wait_state_e;
endpackage

// >>> rtl/lti_wait_timer.sv
`timescale 1ns/1ps
`default_nettype none
module lti_wait_timer
  import lti_pkg::*;
#(
  parameter int STEP_CYCLES = WAIT_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] period,
  input wire logic long_sel,
  output logic busy,
  output logic done
);
  typedef struct packed {
    lti_wait_state_e state;
    logic [16:0] tick;
    logic [11:0] steps;
    logic busy;
    logic done;
  } lti_wait_s;

  lti_wait_s st_q;
  lti_wait_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    case (st_q.state)
      LTI_WAIT_IDLE: begin
        if (start) begin
          // Steps left = (period + 1), times 12 in long-wait mode
          st_d.steps = long_sel ? 12'((12'(period) + 12'h1) * 12'(LONG_WAIT_FACTOR))
                                : 12'(period) + 12'h1; // [R11] [R12]
          st_d.tick = 17'(STEP_CYCLES - 1);
          st_d.state = LTI_WAIT_RUN;
          st_d.busy = 1'b1;
        end
      end
      LTI_WAIT_RUN: begin
        if (st_q.tick != 17'h0) begin
          st_d.tick = st_q.tick - 17'h1;
        end else if (st_q.steps == 12'h1) begin
          st_d.state = LTI_WAIT_IDLE;
          st_d.busy = 1'b0;
          st_d.done = 1'b1;
        end else begin
          st_d.steps = st_q.steps - 12'h1; // [R11]
          st_d.tick = 17'(STEP_CYCLES - 1);
        end
      end
      default: st_d.state = LTI_WAIT_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '{state: LTI_WAIT_IDLE, tick: 17'h0, steps: 12'h0, busy: 1'b0, done: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = st_q.busy;
  assign done = st_q.done;
endmodule
`default_nettype wire

// >>> rtl/lti_core.sv
// Operation
// [R1] Low threshold is the two low-limit bytes as one 16-bit lower limit.
// [R2] Result below low threshold with persistence met sets the light interrupt flag.
// [R3] Result above high threshold with persistence met sets the light interrupt flag.
// [R4] Flag set with interrupt enable drives the active-low interrupt pin.
// [R5] Low-byte writes go to a shadow; high-byte write loads both halves at once.
// [R6] Host writes low byte first, then the matching high byte.
// [R7] Code 0 flags every cycle; code 1 flags any single out-of-range result.
// [R8] Codes 2,3,4 need 2,3,5 results; codes 5..15 need 5*code-15.
// [R9] Count consecutive out-of-range results; interrupt when count equals setting.
// [R10] An in-window result clears the out-of-range counter.
// [R11] Wait timer counts down (setting+1) steps of 2.8 ms.
// [R12] Long-wait bit 2 of the wait-scale register multiplies wait by 12.
// [R13] Host keeps wait-scale bits 7:3 at 10000 and bits 1:0 at 00.
// [R14] Gain field bits 1:0 selects 1x, 4x, 16x, 64x; reset 00.
// [R15] Wait is inserted only while the wait enable is set.
// [R16] Host clears the light interrupt flag by writing a one.
// [R17] Compare and count once per finished integration, on the new result.
`timescale 1ns/1ps
`default_nettype none
module lti_core
  import lti_pkg::*;
#(
  parameter int STEP_CYCLES = WAIT_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic cycle_done,
  input wire logic [15:0] vis_result,
  input wire logic wait_enable,
  input wire logic light_irq_enable,
  input wire logic light_irq_clear,
  output logic light_irq_flag,
  output logic int_out,
  output logic int_oe,
  output logic [1:0] sensor_gain_sel,
  output logic wait_busy,
  output logic wait_done
);
  // ==========================================
  // Persistence decode
  function automatic logic [5:0] persistence_filter_need(input logic [3:0] code);
    logic [5:0] n;
    n = 6'h0;
    case (code)
      4'h0: n = 6'h0;
      4'h1: n = 6'h1;
      4'h2: n = 6'h2;
      4'h3: n = 6'h3;
      4'h4: n = 6'h5;
      default: n = 6'((6'(code) * 6'h5) - 6'hf); // [R8]
    endcase
    return n;
  endfunction

  // Code 1 must fire on every miss, not only on the first miss of a run
  function automatic logic persistence_filter_fire(input logic [3:0] code, input logic outside,
                                     input logic [PERSISTENCE_FILTER_CNT_W-1:0] cnt);
    logic hit;
    hit = 1'b0;
    if (code == 4'h0) begin
      hit = 1'b1; // [R7]
    end else if (code == 4'h1) begin
      hit = outside; // [R7]
    end else begin
      hit = outside && (cnt == persistence_filter_need(code)); // [R8] [R9]
    end
    return hit;
  endfunction

  // Both limits are strict: a result equal to a limit counts as in range
  function automatic logic outside_window(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    return (v < lo) || (v > hi); // [R1] [R2] [R3]
  endfunction

  function automatic logic [15:0] limit_join(input logic [7:0] hi_byte,
                                             input logic [7:0] lo_byte);
    return {hi_byte, lo_byte}; // [R5]
  endfunction

  typedef struct packed {
    logic [7:0] wait_period;
    logic [7:0] low_shadow;
    logic [7:0] high_shadow;
    logic [15:0] low_limit;
    logic [15:0] high_limit;
    logic [7:0] persistence_filter;
    logic [7:0] config_wait_scale;
    logic [7:0] config_gain;
    logic [PERSISTENCE_FILTER_CNT_W-1:0] persistence_filter_cnt;
    logic light_irq_flag;
    logic int_out;
    logic int_oe;
    logic [7:0] rdata;
  } lti_core_s;

  lti_core_s st_q;
  lti_core_s st_d;
  logic out_of_range;
  logic persistence_filter_met;
  logic [PERSISTENCE_FILTER_CNT_W-1:0] cnt_next;
  logic [3:0] persistence_filter_sel;

  // ==========================================
  // Next state
  always_comb begin
    st_d = st_q;
    persistence_filter_sel = st_q.persistence_filter[PERSISTENCE_FILTER_SEL_MSB:0];
    out_of_range = outside_window(vis_result, st_q.low_limit, st_q.high_limit); // [R1] [R2] [R3]
    cnt_next = st_q.persistence_filter_cnt;
    persistence_filter_met = 1'b0;
    if (cycle_done) begin // [R17]
      if (!out_of_range) begin
        cnt_next = '0; // [R10]
      end else if (st_q.persistence_filter_cnt != PERSISTENCE_FILTER_CNT_MAX) begin
        cnt_next = st_q.persistence_filter_cnt + 6'h1; // [R9]
      end
      // Code 0 fires on every cycle regardless of range
      persistence_filter_met = persistence_filter_fire(persistence_filter_sel, out_of_range, cnt_next); // [R7] [R9]
    end
    st_d.persistence_filter_cnt = cnt_next;

    // ==========================================
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_WAIT_PERIOD: st_d.wait_period = reg_wdata;
        OFS_LOW_LIMIT_LOW_BYTE: st_d.low_shadow = reg_wdata; // [R5]
        OFS_LOW_LIMIT_HIGH_BYTE: st_d.low_limit = limit_join(reg_wdata, st_q.low_shadow); // [R5]
        OFS_HIGH_LIMIT_LOW_BYTE: st_d.high_shadow = reg_wdata; // [R5]
        OFS_HIGH_LIMIT_HIGH_BYTE: st_d.high_limit = limit_join(reg_wdata, st_q.high_shadow); // [R5]
        OFS_PERSISTENCE_FILTER: st_d.persistence_filter = reg_wdata;
        // Reserved bits are stored as written; software must keep them
        OFS_CONFIG_WAIT_SCALE: st_d.config_wait_scale = reg_wdata; // [R13]
        OFS_CONFIG_GAIN: st_d.config_gain = reg_wdata;
        default: st_d.rdata = st_d.rdata;
      endcase
    end

    // ==========================================
    // Interrupt flag and pin
    // A new event beats a same-cycle clear so no interrupt is lost
    if (persistence_filter_met) begin
      st_d.light_irq_flag = 1'b1; // [R2] [R3]
    end else if (light_irq_clear) begin
      st_d.light_irq_flag = 1'b0; // [R16]
    end
    st_d.int_out = 1'b0;
    st_d.int_oe = st_d.light_irq_flag && light_irq_enable; // [R4]

    // ==========================================
    // Read data, one cycle behind the address
    case (reg_addr)
      OFS_WAIT_PERIOD: st_d.rdata = st_q.wait_period;
      OFS_LOW_LIMIT_LOW_BYTE: st_d.rdata = st_q.low_shadow;
      OFS_LOW_LIMIT_HIGH_BYTE: st_d.rdata = st_q.low_limit[15:8];
      OFS_HIGH_LIMIT_LOW_BYTE: st_d.rdata = st_q.high_shadow;
      OFS_HIGH_LIMIT_HIGH_BYTE: st_d.rdata = st_q.high_limit[15:8];
      OFS_PERSISTENCE_FILTER: st_d.rdata = st_q.persistence_filter;
      OFS_CONFIG_WAIT_SCALE: st_d.rdata = st_q.config_wait_scale;
      OFS_CONFIG_GAIN: st_d.rdata = st_q.config_gain;
      default: st_d.rdata = 8'h00;
    endcase
  end

  // ==========================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '{
        wait_period: RST_WAIT_PERIOD,
        low_shadow: RST_LIMIT_BYTE,
        high_shadow: RST_LIMIT_BYTE,
        low_limit: {RST_LIMIT_BYTE, RST_LIMIT_BYTE},
        high_limit: {RST_LIMIT_BYTE, RST_LIMIT_BYTE},
        persistence_filter: RST_PERSISTENCE_FILTER,
        config_wait_scale: RST_CONFIG_WAIT_SCALE,
        config_gain: RST_CONFIG_GAIN,
        persistence_filter_cnt: '0,
        light_irq_flag: 1'b0,
        int_out: 1'b0,
        int_oe: 1'b0,
        rdata: 8'h00
      };
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================
  // Wait timer between conversion cycles
  lti_wait_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_wait (
    .clk(clk),
    .rst_n(rst_n),
    .start(cycle_done && wait_enable), // [R15]
    .period(st_q.wait_period),
    .long_sel(st_q.config_wait_scale[LONG_WAIT_BIT]), // [R12]
    .busy(wait_busy),
    .done(wait_done)
  );

  assign reg_rdata = st_q.rdata;
  assign light_irq_flag = st_q.light_irq_flag;
  assign int_out = st_q.int_out;
  assign int_oe = st_q.int_oe;
  assign sensor_gain_sel = st_q.config_gain[GAIN_SEL_MSB:0]; // [R14]
endmodule
`default_nettype wire

// >>> sim/lti_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lti_monitor
  import lti_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic cycle_done,
  input wire logic wait_enable,
  input wire logic light_irq_enable,
  input wire logic light_irq_clear,
  input wire logic light_irq_flag,
  input wire logic int_out,
  input wire logic int_oe,
  input wire logic [1:0] sensor_gain_sel,
  input wire logic wait_busy,
  input wire logic wait_done
);
  // ==========================================
  // Shadow of the persistence code, seen from the write strobe
  logic [3:0] persistence_filter_q;
  always_ff @(posedge clk) begin
    if (!rst_n) persistence_filter_q <= 4'h0;
    else if (reg_wr && reg_addr == OFS_PERSISTENCE_FILTER) persistence_filter_q <= reg_wdata[3:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_every;
    cycle_done && persistence_filter_q == 4'h0;
  endsequence
  sequence s_end;
    $past(wait_busy) ##0 !wait_busy;
  endsequence
  AST_PERS0: assert property (s_every |=> light_irq_flag)
    else $error("flag missing with code zero");
  AST_RISE: assert property ($rose(light_irq_flag) |-> $past(cycle_done))
    else $error("flag rose without a result");
  AST_CLR: assert property (light_irq_clear && !cycle_done |=> !light_irq_flag)
    else $error("flag not cleared");
  AST_FELL: assert property ($fell(light_irq_flag) |-> $past(light_irq_clear))
    else $error("flag dropped by itself");
  AST_OE: assert property (int_oe == (light_irq_flag && $past(light_irq_enable)))
    else $error("pin enable wrong");
  AST_PIN: assert property (int_out == 1'b0)
    else $error("pin drives high");
  AST_WSTART: assert property (cycle_done && wait_enable && !wait_busy |=> wait_busy)
    else $error("wait not started");
  AST_WRISE: assert property ($rose(wait_busy) |-> $past(cycle_done && wait_enable))
    else $error("wait started unasked");
  AST_WDONE: assert property (wait_done |-> s_end ##1 !wait_done)
    else $error("wait end malformed");
  AST_GAIN: assert property (
    reg_wr && reg_addr == OFS_CONFIG_GAIN |=> sensor_gain_sel == $past(reg_wdata[1:0]))
    else $error("gain not updated");
endmodule
bind lti_core lti_monitor u_lti_monitor (.*);
`default_nettype wire

// >>> sim/lti_host.sv
`timescale 1ns/1ps
`default_nettype none
module lti_host
  import lti_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // Read data lags the address by one edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic thr(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask
  task automatic cfg_wait(input logic lng);
    wr(OFS_CONFIG_WAIT_SCALE, {5'h10, lng, 2'h0});
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lti_pkg::*;
  localparam int STEP = 3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic cycle_done = 1'b0;
  logic [15:0] vis_result = 16'h0000;
  logic wait_enable = 1'b0;
  logic light_irq_enable = 1'b0;
  logic light_irq_clear = 1'b0;
  logic light_irq_flag, int_out, int_oe, wait_busy, wait_done;
  logic [1:0] sensor_gain_sel;
  int errors = 0;
  int tests_run = 0;
  int n;
  int need;
  always #20 clk = ~clk;
  lti_core #(.STEP_CYCLES(STEP)) u_lti_core (.*);
  lti_host u_lti_host (.*);
  // ==========================================
  // Checking and stimulus helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Ends one and a half cycles after the taking edge, when the flag has landed
  task automatic conv(input logic [15:0] v);
    @(negedge clk);
    cycle_done = 1'b1;
    vis_result = v;
    @(negedge clk);
    cycle_done = 1'b0;
    vis_result = ~v;
    @(negedge clk);
  endtask
  task automatic clr();
    @(negedge clk);
    light_irq_clear = 1'b1;
    @(negedge clk);
    light_irq_clear = 1'b0;
  endtask
  task automatic cf(input logic [15:0] v, input logic e);
    clr();
    conv(v);
    chk(light_irq_flag, e);
  endtask
  task automatic tw(input int e);
    conv(16'h0150);
    n = 1;
    while (wait_done !== 1'b1 && n < 999) begin
      @(negedge clk);
      n++;
    end
    chk(n[15:0], e[15:0]);
  endtask
  localparam logic [7:0] RA [5] = '{8'h8d, 8'h88, 8'h90, 8'h84, 8'h87};
  localparam logic [7:0] RE [5] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  // The second miss in a row must also fire with code 1
  localparam logic [15:0] CV [5] = '{16'h0100, 16'h00ff, 16'h0300, 16'h0200, 16'h0201};
  localparam logic CE [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  initial begin
    #2000000;
    errors++;
    close_out();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    foreach (RA[i]) begin
      u_lti_host.rd(RA[i], rv);
      chk(rv, RE[i]);
    end
    u_lti_host.wr(OFS_PERSISTENCE_FILTER, 8'h01);
    u_lti_host.thr(OFS_LOW_LIMIT_LOW_BYTE, 16'h0180);
    u_lti_host.thr(OFS_HIGH_LIMIT_LOW_BYTE, 16'h0200);
    // A lone low byte must not move the active limit
    u_lti_host.wr(OFS_LOW_LIMIT_LOW_BYTE, 8'h00);
    cf(16'h0150, 1'b1);
    u_lti_host.wr(OFS_LOW_LIMIT_HIGH_BYTE, 8'h01);
    cf(16'h0150, 1'b0);
    light_irq_enable = 1'b1;
    foreach (CV[i]) cf(CV[i], CE[i]);
    chk(int_oe, 1'b1);
    u_lti_host.wr(OFS_PERSISTENCE_FILTER, 8'h00);
    cf(16'h0150, 1'b1);
    for (int c = 2; c < 16; c++) begin
      need = c < 4 ? c : c == 4 ? 5 : 5 * c - 15;
      u_lti_host.wr(OFS_PERSISTENCE_FILTER, c[7:0]);
      conv(16'h0150);
      clr();
      repeat (need - 1) conv(16'h0300);
      conv(16'h0150);
      repeat (need - 1) conv(16'h0300);
      chk(light_irq_flag, 1'b0);
      conv(16'h0300);
      chk(light_irq_flag, 1'b1);
    end
    for (int g = 0; g < 4; g++) begin
      u_lti_host.wr(OFS_CONFIG_GAIN, {6'h00, g[1:0]});
      chk(sensor_gain_sel, g[15:0]);
    end
    u_lti_host.wr(OFS_WAIT_PERIOD, 8'h01);
    conv(16'h0150);
    chk(wait_busy, 1'b0);
    wait_enable = 1'b1;
    // The done pulse lands steps times STEP edges after the taking edge
    tw(2 * STEP);
    u_lti_host.cfg_wait(1'b1);
    u_lti_host.rd(OFS_CONFIG_WAIT_SCALE, rv);
    chk(rv, 8'h84);
    tw(24 * STEP);
    close_out();
  end
endmodule
`default_nettype wire
